// File: core/tmr8_compare.sv
// 8-bit timer/counter: normal and clear-on-match modes, two compare outputs, axi4-lite slave
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module tmr8_compare
  import tmr8_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // axi4-lite write address
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // axi4-lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // axi4-lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read address
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // axi4-lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // interrupt acknowledges from the processor, same clock
  input wire logic OVF_ACK,
  input wire logic CMPA_ACK,
  input wire logic CMPB_ACK,
  // external count source pin
  input wire logic EXT_CLK_PIN,
  // compare output pins
  output logic [1:0] PIN_OUT,
  output logic [1:0] PIN_OE,
  // interrupt flags
  output logic OVF_FLAG,
  output logic [1:0] CMP_FLAG
);
  // bus slave
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;

  // address and data captured in either order, then one write happens
  assign wr_fire = aw_held_reg && w_held_reg && !BVALID;

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      if (AWVALID && !aw_held_reg && !AWREADY) begin
        AWREADY <= 1'b1;
        aw_held_reg <= 1'b1;
        awaddr_reg <= AWADDR;
      end
      if (WVALID && !w_held_reg && !WREADY) begin
        WREADY <= 1'b1;
        w_held_reg <= 1'b1;
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
      end
      if (wr_fire) begin
        BVALID <= 1'b1;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        BRESP <= (awaddr_reg[1:0] == 2'h0 && awaddr_reg <= OFS_PORT) ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // decoded write strobes, one cycle each; byte lane 0 carries data, except control, whose clock select comes from lane 1
  logic wr_lane0;
  logic wr_ctrl;
  logic wr_count;
  logic wr_cmpa;
  logic wr_cmpb;
  logic wr_flags;
  logic wr_force;
  logic wr_port;
  assign wr_lane0 = wr_fire && wstrb_reg[0];
  assign wr_ctrl = wr_fire && awaddr_reg == OFS_CTRL;
  assign wr_count = wr_lane0 && awaddr_reg == OFS_COUNT;
  assign wr_cmpa = wr_lane0 && awaddr_reg == OFS_CMPA;
  assign wr_cmpb = wr_lane0 && awaddr_reg == OFS_CMPB;
  assign wr_flags = wr_lane0 && awaddr_reg == OFS_FLAGS;
  assign wr_force = wr_lane0 && awaddr_reg == OFS_FORCE;
  assign wr_port = wr_lane0 && awaddr_reg == OFS_PORT;

  // control registers
  ctrl_t ctrl_reg;
  logic [7:0] count_reg;
  logic [7:0] cmpa_reg;
  logic [7:0] cmpb_reg;
  logic [1:0] port_val_reg;
  logic [1:0] port_dir_reg;

  // action bits are unbuffered: a write steers the very next match
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ctrl_reg <= '0;
    end else if (wr_ctrl) begin
      if (wstrb_reg[0]) begin
        ctrl_reg.compare_output_action_a <= wdata_reg[CTRL_ACTA_POS +: 2];
        ctrl_reg.compare_output_action_b <= wdata_reg[CTRL_ACTB_POS +: 2];
        ctrl_reg.waveform_sequence_select <= wdata_reg[CTRL_WGM_POS +: 3];
      end
      if (wstrb_reg[1]) begin
        ctrl_reg.clock_source_select <= wdata_reg[CTRL_CSEL_POS +: 3];
      end
    end
  end

  // compare values go straight to the active registers, no buffering
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      cmpa_reg <= CMP_RST;
      cmpb_reg <= CMP_RST;
    end else begin
      if (wr_cmpa) cmpa_reg <= wdata_reg[7:0];
      if (wr_cmpb) cmpb_reg <= wdata_reg[7:0];
    end
  end

  // general port value and direction bits
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      port_val_reg <= 2'h0;
      port_dir_reg <= 2'h0;
    end else if (wr_port) begin
      port_val_reg <= wdata_reg[PRT_VAL_POS +: 2];
      port_dir_reg <= wdata_reg[PRT_DIR_POS +: 2];
    end
  end

  // prescaler and timer tick
  logic [9:0] pre_reg;
  logic [2:0] ext_sync_reg;
  logic tick;
  logic ext_rise;
  logic ext_fall;

  // external pin passes two flops; edge found between second and third
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ext_sync_reg <= 3'h0;
      pre_reg <= 10'h000;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], EXT_CLK_PIN};
      pre_reg <= pre_reg + 10'h001;
    end
  end
  assign ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];
  assign ext_fall = !ext_sync_reg[1] && ext_sync_reg[2];

  // select zero produces no tick, so the counter holds
  always_comb begin
    case (ctrl_reg.clock_source_select)
      3'h1: tick = 1'b1;
      3'h2: tick = pre_reg[2:0] == DIV8_LAST[2:0];
      3'h3: tick = pre_reg[5:0] == DIV64_LAST[5:0];
      3'h4: tick = pre_reg[7:0] == DIV256_LAST[7:0];
      3'h5: tick = pre_reg == DIV1024_LAST;
      3'h6: tick = ext_fall;
      3'h7: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // counter and compare
  logic is_normal;
  logic is_clear;
  logic block_reg;
  logic [1:0] eq;
  logic [1:0] match;
  logic [7:0] count_next;
  assign is_normal = ctrl_reg.waveform_sequence_select == WGM_NORMAL;
  assign is_clear = ctrl_reg.waveform_sequence_select == WGM_CLEAR;
  assign eq = {count_reg == cmpb_reg, count_reg == cmpa_reg};
  // a count write blocks matches until a tick has passed, even when stopped
  assign match = (tick && !block_reg) ? eq : 2'h0;

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      block_reg <= 1'b0;
    end else if (wr_count) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  // sequence depends on waveform select and compare a only
  always_comb begin
    count_next = count_reg + 8'h01; // wraps ff to 00
    if (is_clear && eq[0]) count_next = CNT_BOTTOM; // top is compare a
  end

  // write beats counting, accepted at any time
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      count_reg <= COUNT_RST;
    end else if (wr_count) begin
      count_reg <= wdata_reg[7:0];
    end else if (tick) begin
      count_reg <= count_next;
    end
  end

  // flags
  logic ovf_set;
  cmp_flags_t flags_reg;
  // overflow when counter passes max to bottom, only in counting steps of normal and clear-on-match modes
  assign ovf_set = tick && !wr_count && (is_normal || is_clear) && count_reg == CNT_MAX;

  // set wins over acknowledge or write-one-to-clear
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      OVF_FLAG <= 1'b0;
    end else if (ovf_set) begin
      OVF_FLAG <= 1'b1;
    end else if (OVF_ACK || (wr_flags && wdata_reg[FLG_OVF_POS])) begin
      OVF_FLAG <= 1'b0;
    end
  end

  // compare flag raised at the tick after equality; force never sets it
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      flags_reg <= '0;
    end else begin
      if (match[0]) flags_reg.flag_a <= 1'b1;
      else if (CMPA_ACK || (wr_flags && wdata_reg[FLG_CMPA_POS])) flags_reg.flag_a <= 1'b0;
      if (match[1]) flags_reg.flag_b <= 1'b1;
      else if (CMPB_ACK || (wr_flags && wdata_reg[FLG_CMPB_POS])) flags_reg.flag_b <= 1'b0;
    end
  end
  assign CMP_FLAG = {flags_reg.flag_b, flags_reg.flag_a};

  // compare output latches and pins
  logic [1:0] latch_reg;
  logic [1:0] force_hit;
  logic [3:0] act_pair;
  assign act_pair = {ctrl_reg.compare_output_action_b, ctrl_reg.compare_output_action_a};
  // forcing only allowed in the non-pwm sequences
  assign force_hit = (wr_force && (is_normal || is_clear)) ?
                     wdata_reg[FRC_A_POS +: 2] : 2'h0;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [1:0] act;
      assign act = act_pair[2*ch +: 2];
      // reset clears latch; mode changes leave it alone
      always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
          latch_reg[ch] <= 1'b0;
        end else if (match[ch] || force_hit[ch]) begin
          case (act)
            ACT_TOGGLE: latch_reg[ch] <= !latch_reg[ch];
            ACT_CLEAR: latch_reg[ch] <= 1'b0;
            ACT_SET: latch_reg[ch] <= 1'b1;
            default: latch_reg[ch] <= latch_reg[ch];
          endcase
        end
      end
      // latch overrides port value when action nonzero; direction stays port's
      always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
          PIN_OUT[ch] <= 1'b0;
          PIN_OE[ch] <= 1'b0;
        end else begin
          PIN_OUT[ch] <= (act != ACT_NONE) ? latch_reg[ch] : port_val_reg[ch];
          PIN_OE[ch] <= port_dir_reg[ch];
        end
      end
    end
  endgenerate

  // read channel
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    case (ARADDR)
      OFS_CTRL: rd_word = {21'h0, ctrl_reg.clock_source_select, 1'b0,
                           ctrl_reg.waveform_sequence_select, act_pair};
      OFS_COUNT: rd_word = {24'h0, count_reg};
      OFS_CMPA: rd_word = {24'h0, cmpa_reg};
      OFS_CMPB: rd_word = {24'h0, cmpb_reg};
      OFS_FLAGS: rd_word = {29'h0, CMP_FLAG, OVF_FLAG};
      OFS_FORCE: rd_word = {30'h0, latch_reg};
      OFS_PORT: rd_word = {28'h0, port_dir_reg, port_val_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  // single-beat reads, RVALID raised in the same cycle as ARREADY
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= RESP_OKAY;
    end else begin
      ARREADY <= 1'b0;
      if (ARVALID && !ARREADY && !RVALID) begin
        ARREADY <= 1'b1;
        RVALID <= 1'b1;
        RDATA <= rd_word;
        RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // assertions
  a_reset_latch_zero: assert property (@(posedge MCLK) $fell(RESET) |-> latch_reg == 2'h0)
    else $error("latch not zero after reset");
  a_write_blocks_flag: assert property (@(posedge MCLK) disable iff (RESET)
    wr_count |=> !match[0] && !match[1])
    else $error("match not blocked after count write");
  a_force_no_flag: assert property (@(posedge MCLK) disable iff (RESET)
    (force_hit[0] && !match[0] && !CMPA_ACK && !flags_reg.flag_a) |=> !flags_reg.flag_a)
    else $error("force set the compare flag");
  a_normal_wrap: assert property (@(posedge MCLK) disable iff (RESET)
    (tick && !wr_count && is_normal && count_reg == CNT_MAX) |=> count_reg == CNT_BOTTOM)
    else $error("normal mode did not wrap");
  a_ovf_set_wrap: assert property (@(posedge MCLK) disable iff (RESET)
    ovf_set |=> OVF_FLAG && count_reg == CNT_BOTTOM)
    else $error("overflow flag not set at wrap");
  a_clear_on_top: assert property (@(posedge MCLK) disable iff (RESET)
    (tick && !wr_count && is_clear && count_reg == cmpa_reg) |=> count_reg == CNT_BOTTOM)
    else $error("counter not cleared at compare a");
  a_toggle_on_match: assert property (@(posedge MCLK) disable iff (RESET)
    (match[0] && ctrl_reg.compare_output_action_a == ACT_TOGGLE) |=> latch_reg[0] != $past(latch_reg[0]))
    else $error("latch a did not toggle");
  a_hold_no_action: assert property (@(posedge MCLK) disable iff (RESET)
    (ctrl_reg.compare_output_action_a == ACT_NONE) |=> $stable(latch_reg[0]))
    else $error("latch a changed with action zero");
  a_stopped_holds: assert property (@(posedge MCLK) disable iff (RESET)
    (ctrl_reg.clock_source_select == 3'h0 && !wr_count) |=> $stable(count_reg))
    else $error("counter moved while stopped");
  a_flag_after_match: assert property (@(posedge MCLK) disable iff (RESET)
    match[1] |=> flags_reg.flag_b)
    else $error("compare flag b not set after match");
  a_pin_override: assert property (@(posedge MCLK) disable iff (RESET)
    (ctrl_reg.compare_output_action_b != ACT_NONE) |=> PIN_OUT[1] == $past(latch_reg[1]))
    else $error("pin b not driven from latch");
endmodule : tmr8_compare
`default_nettype wire

// File: core/tmr8_pkg.sv
// package: constants, register map and types of the 8-bit compare timer
package tmr8_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_CMPA = 8'h08;
  localparam logic [7:0] OFS_CMPB = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_FORCE = 8'h14;
  localparam logic [7:0] OFS_PORT = 8'h18;
  // control register fields
  localparam int CTRL_ACTA_POS = 0;
  localparam int CTRL_ACTB_POS = 2;
  localparam int CTRL_WGM_POS = 4;
  localparam int CTRL_CSEL_POS = 8;
  // flag register fields
  localparam int FLG_OVF_POS = 0;
  localparam int FLG_CMPA_POS = 1;
  localparam int FLG_CMPB_POS = 2;
  // force register / port register fields
  localparam int FRC_A_POS = 0;
  localparam int FRC_B_POS = 1;
  localparam int PRT_VAL_POS = 0;
  localparam int PRT_DIR_POS = 2;
  // reset values and counter limits
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  // waveform sequence encodings handled here
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_CLEAR = 3'h2;
  // compare output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // prescale terminal counts (divide minus one)
  localparam logic [9:0] DIV8_LAST = 10'h007;
  localparam logic [9:0] DIV64_LAST = 10'h03F;
  localparam logic [9:0] DIV256_LAST = 10'h0FF;
  localparam logic [9:0] DIV1024_LAST = 10'h3FF;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control settings carried together
  typedef struct packed {
    logic [2:0] clock_source_select;
    logic [2:0] waveform_sequence_select;
    logic [1:0] compare_output_action_b;
    logic [1:0] compare_output_action_a;
  } ctrl_t;
  // per-channel compare state
  typedef struct packed {
    logic flag_b;
    logic flag_a;
  } cmp_flags_t;
endpackage : tmr8_pkg

// File: tb/pad_model.sv
// pad model: output port pin with a pull-up when not driven
`timescale 1ns/100ps
`default_nettype none
module pad_model (
  // driver side
  input wire logic drv,
  input wire logic oe,
  // pad level
  output logic pad
);
  // released pin floats to the pull-up, never the last value
  assign pad = oe ? drv : 1'b1;
endmodule : pad_model
`default_nettype wire

// File: tb/timer8_compare_normal_ctc_tb.sv
// testbench: compare outputs, normal and clear-on-match modes
`timescale 1ns/100ps
`default_nettype none
module timer8_compare_normal_ctc_tb;
  import tmr8_pkg::*;
  logic mclk = 0, reset = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, ovf_flag, ovf_ack = 0, cmpa_ack = 0;
  logic [1:0] bresp, rresp, pin_out, pin_oe, cmp_flag;
  logic pad_a;
  logic ext_clk = 0, cmpb_ack = 0;
  logic [1:0] last_bresp;
  int failures = 0, n_tests = 0;

  tmr8_compare uut (.MCLK(mclk), .RESET(reset), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .OVF_ACK(ovf_ack), .CMPA_ACK(cmpa_ack), .CMPB_ACK(cmpb_ack), .EXT_CLK_PIN(ext_clk),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .OVF_FLAG(ovf_flag), .CMP_FLAG(cmp_flag));
  pad_model pad (.drv(pin_out[0]), .oe(pin_oe[0]), .pad(pad_a));

  // 125 MHz
  always #4 mclk = ~mclk;

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  // write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw;
    ta = 0;
    tw = 0;
    // start on an edge so the previous release of bready is not overwritten
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      if (awready) begin ta = 1; awvalid <= 0; end
      if (wready) begin tw = 1; wvalid <= 0; end
    end while (!(ta && tw && bvalid));
    last_bresp = bresp;
    bready <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask : rd

  function automatic logic [31:0] ctrl(logic [1:0] act, logic [2:0] wgm, logic [2:0] cs);
    return (32'(act) << CTRL_ACTA_POS) | (32'(wgm) << CTRL_WGM_POS) | (32'(cs) << CTRL_CSEL_POS);
  endfunction : ctrl

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_cycles

  // after reset: pin value low, pin released, counter clear, unmapped read and write rejected
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    chk_bit(pin_out[0], 1'b0);
    chk_bit(pad_a, 1'b1);
    rd(OFS_COUNT, d, r);
    chk_word(d, 32'h0000_0000);
    rd(8'h40, d, r);
    chk_word({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h41, 32'h0000_0000);
    chk_word({30'h0, last_bresp}, {30'h0, RESP_SLVERR});
  endtask : t_reset

  // force strobe with each action, override, hold across action and mode change
  task automatic t_force;
    logic [1:0] acts [6] = '{ACT_SET, ACT_TOGGLE, ACT_TOGGLE, ACT_NONE, ACT_CLEAR, ACT_CLEAR};
    logic [2:0] modes [6] = '{WGM_NORMAL, WGM_NORMAL, WGM_NORMAL, WGM_NORMAL, WGM_CLEAR,
      WGM_CLEAR};
    bit frc [6] = '{1, 1, 1, 1, 0, 1};
    logic expv [6] = '{1, 0, 1, 0, 1, 0};
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_COUNT, 32'h0000_0033);
    chk_word({30'h0, last_bresp}, {30'h0, RESP_OKAY});
    wr(OFS_PORT, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CTRL, ctrl(acts[i], modes[i], 3'h0));
      if (frc[i]) wr(OFS_FORCE, 32'h0000_0001);
      // latch set up first, then the pin turned to output
      if (i == 0) wr(OFS_PORT, 32'h0000_0004);
      wait_cycles(3);
      chk_bit(pad_a, expv[i]);
    end
    chk_word({30'h0, cmp_flag}, 32'h0000_0000);
    rd(OFS_COUNT, d, r);
    chk_word(d, 32'h0000_0033);
  endtask : t_force

  // overflow in normal mode, cleared by the interrupt acknowledge
  task automatic t_overflow;
    int k;
    wr(OFS_CTRL, ctrl(ACT_NONE, WGM_NORMAL, 3'h1));
    wr(OFS_COUNT, 32'h0000_00F0);
    k = 0;
    while (ovf_flag !== 1'b1 && k < 100) begin wait_cycles(1); k++; end
    chk_bit(ovf_flag, 1'b1);
    wr(OFS_CTRL, ctrl(ACT_NONE, WGM_NORMAL, 3'h0));
    ovf_ack <= 1;
    @(posedge mclk);
    ovf_ack <= 0;
    wait_cycles(2);
    chk_bit(ovf_flag, 1'b0);
  endtask : t_overflow

  // a count write equal to compare a hides that match; a later one is flagged
  task automatic t_block;
    int k;
    wr(OFS_CMPA, 32'h0000_0040);
    wr(OFS_FLAGS, 32'h0000_0007);
    wr(OFS_CTRL, ctrl(ACT_NONE, WGM_NORMAL, 3'h1));
    wr(OFS_COUNT, 32'h0000_0040);
    k = 0;
    repeat (20) begin wait_cycles(1); if (cmp_flag[0] === 1'b1) k++; end
    chk_word(32'(k), 32'h0000_0000);
    wr(OFS_COUNT, 32'h0000_0030);
    k = 0;
    while (cmp_flag[0] !== 1'b1 && k < 40) begin wait_cycles(1); k++; end
    chk_bit(cmp_flag[0], 1'b1);
    wr(OFS_FLAGS, 32'h0000_0002);
    wait_cycles(1);
    chk_bit(cmp_flag[0], 1'b0);
  endtask : t_block

  // clear-on-match toggle: half period is prescale times one plus compare
  task automatic t_ctc;
    logic [2:0] cs [6] = '{3'h1, 3'h2, 3'h1, 3'h3, 3'h4, 3'h5};
    logic [7:0] top [6] = '{8'h03, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    int half [6] = '{4, 16, 1, 64, 256, 1024};
    int n;
    logic p;
    for (int i = 0; i < 6; i++) begin
      // waveform off before the count is rewritten
      wr(OFS_CTRL, ctrl(ACT_NONE, WGM_NORMAL, 3'h0));
      wr(OFS_COUNT, 32'h0000_0000);
      wr(OFS_CMPA, {24'h0, top[i]});
      wr(OFS_FLAGS, 32'h0000_0007);
      wr(OFS_CTRL, ctrl(ACT_TOGGLE, WGM_CLEAR, cs[i]));
      wait_cycles(40);
      p = pin_out[0];
      n = 0;
      while (pin_out[0] === p && n < 2100) begin wait_cycles(1); n++; end
      p = pin_out[0];
      n = 0;
      while (pin_out[0] === p && n < 2100) begin wait_cycles(1); n++; end
      chk_word(32'(n), 32'(half[i]));
      chk_bit(cmp_flag[0], 1'b1);
      chk_bit(ovf_flag, 1'b0);
      @(posedge mclk);
      cmpa_ack <= 1;
      @(posedge mclk);
      cmpa_ack <= 0;
    end
    wr(OFS_CTRL, ctrl(ACT_NONE, WGM_NORMAL, 3'h0));
  endtask : t_ctc

  // compare a written below the count: counter runs through max and overflows first
  task automatic t_miss;
    int k;
    wr(OFS_COUNT, 32'h0000_0020);
    wr(OFS_CMPA, 32'h0000_0010);
    wr(OFS_FLAGS, 32'h0000_0007);
    wr(OFS_CTRL, ctrl(ACT_NONE, WGM_CLEAR, 3'h1));
    k = 0;
    while (ovf_flag !== 1'b1 && k < 300) begin wait_cycles(1); k++; end
    chk_bit(ovf_flag, 1'b1);
    chk_bit(cmp_flag[0], 1'b0);
    k = 0;
    while (cmp_flag[0] !== 1'b1 && k < 40) begin wait_cycles(1); k++; end
    chk_bit(cmp_flag[0], 1'b1);
    wr(OFS_CTRL, ctrl(ACT_NONE, WGM_NORMAL, 3'h0));
  endtask : t_miss

  // channel b on the external rising edge: action rewrite, acknowledge, override, direction
  task automatic t_chan_b;
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_COUNT, 32'h0000_0000);
    wr(OFS_CMPB, 32'h0000_0002);
    wr(OFS_FLAGS, 32'h0000_0007);
    wr(OFS_PORT, 32'h0000_000C);
    wr(OFS_CTRL, (32'(ACT_SET) << CTRL_ACTB_POS) | ctrl(ACT_NONE, WGM_NORMAL, 3'h7));
    wr(OFS_FORCE, 32'h0000_0002);
    wait_cycles(3);
    chk_bit(pin_out[1], 1'b1);
    chk_bit(pin_oe[1], 1'b1);
    chk_bit(cmp_flag[1], 1'b0);
    wr(OFS_CTRL, (32'(ACT_CLEAR) << CTRL_ACTB_POS) | ctrl(ACT_NONE, WGM_NORMAL, 3'h7));
    // three slow pin pulses, each seen as one tick after the synchroniser
    repeat (3) begin
      @(posedge mclk);
      ext_clk <= 1;
      repeat (4) @(posedge mclk);
      ext_clk <= 0;
      repeat (3) @(posedge mclk);
    end
    wait_cycles(3);
    chk_bit(cmp_flag[1], 1'b1);
    chk_bit(pin_out[1], 1'b0);
    rd(OFS_COUNT, d, r);
    chk_word(d, 32'h0000_0003);
    @(posedge mclk);
    cmpb_ack <= 1;
    @(posedge mclk);
    cmpb_ack <= 0;
    wait_cycles(1);
    chk_bit(cmp_flag[1], 1'b0);
    wr(OFS_PORT, 32'h0000_000E);
    wait_cycles(2);
    chk_bit(pin_out[1], 1'b0);
    wr(OFS_CTRL, ctrl(ACT_NONE, WGM_NORMAL, 3'h0));
    wait_cycles(2);
    chk_bit(pin_out[1], 1'b1);
    wr(OFS_PORT, 32'h0000_0004);
    wait_cycles(2);
    chk_bit(pin_oe[1], 1'b0);
  endtask : t_chan_b

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 0;
    wait_cycles(1);
    t_reset();
    t_force();
    t_overflow();
    t_block();
    t_ctc();
    t_miss();
    t_chan_b();
    give_verdict();
  end

  // watchdog, far beyond the few thousand cycles the scenarios need
  initial begin
    #400000;
    failures++;
    give_verdict();
  end
endmodule : timer8_compare_normal_ctc_tb
`default_nettype wire
